// >>> core/asu_divider.sv
// Sequential restoring divider, 32-bit dividend by 16-bit divisor.
// Assumes a nonzero divisor; the caller screens zero and oversized divisors.
module asu_divider (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        start,
    input  wire logic [31:0] dividend,
    input  wire logic [15:0] divisor,
    output logic             done,
    output logic [31:0]      quotient,
    output logic [15:0]      remainder
);
    asu_pkg::asu_div_state_t d_r;
    asu_pkg::asu_div_state_t d_nxt;

    always_comb begin
        logic [16:0] shifted;
        shifted = '0;
        d_nxt = d_r;
        d_nxt.done = 1'b0;
        if (start) begin
            d_nxt.quo     = dividend;
            d_nxt.rem     = '0;
            d_nxt.divisor = divisor;
            d_nxt.cnt     = '0;
            d_nxt.run     = 1'b1;
        end else if (d_r.run) begin
            // One quotient bit per cycle keeps the adder at 17 bits
            shifted = {d_r.rem[15:0], d_r.quo[31]};
            if (shifted >= {1'b0, d_r.divisor}) begin
                d_nxt.rem = shifted - {1'b0, d_r.divisor};
                d_nxt.quo = {d_r.quo[30:0], 1'b1};
            end else begin
                d_nxt.rem = shifted;
                d_nxt.quo = {d_r.quo[30:0], 1'b0};
            end
            d_nxt.cnt = d_r.cnt + 6'h01;
            if (d_r.cnt == asu_pkg::DIV_LAST) begin
                d_nxt.run  = 1'b0;
                d_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            d_r <= '0;
        end else begin
            d_r <= d_nxt;
        end
    end

    assign done      = d_r.done;
    assign quotient  = d_r.quo;
    assign remainder = d_r.rem[15:0];
endmodule

// >>> core/asu_pkg.sv
// Constants, register map and state types of the accumulator stack arithmetic unit.
// Assumes a single clock domain and a 32-bit AHB-Lite register bus.
package asu_pkg;

    localparam int          STACK_DEPTH   = 8;
    localparam int          WORD_W        = 32;
    localparam int          HALF_W        = 16;
    localparam int          DIGITS_ACC    = 8;
    localparam int          DIGITS_DIVSR  = 4;
    localparam int          DIV_STEPS     = 32;
    localparam logic [5:0]  DIV_LAST      = 6'h1F;

    // Register byte addresses
    localparam logic [7:0]  ADDR_CMD      = 8'h00;
    localparam logic [7:0]  ADDR_ACC      = 8'h04;
    localparam logic [7:0]  ADDR_STATUS   = 8'h08;
    // Stack level n (1..8) reads at 0x20 + 4*(n-1)
    localparam logic [2:0]  ADDR_STK_REGION = 3'h1;

    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'h0;
    localparam logic [3:0]  BCD_MAX_DIGIT = 4'h9;
    localparam logic [3:0]  DABBLE_LIMIT  = 4'h4;
    localparam logic [3:0]  DABBLE_ADD    = 4'h3;
    localparam logic [31:0] TEN           = 32'h0000000A;

    // Status flag positions
    localparam int          FLG_OVF       = 0;
    localparam int          FLG_ZERO      = 1;
    localparam int          FLG_CARRY16   = 2;
    localparam int          FLG_CARRY32   = 3;
    localparam int          FLG_NEG       = 4;
    localparam int          FLG_SIGN_ERR  = 5;
    localparam int          FLG_NON_BCD   = 6;
    localparam int          FLG_BORROW16  = 7;
    localparam int          FLG_BORROW32  = 8;
    localparam int          FLAG_W        = 9;
    localparam int          STATUS_BUSY   = 16;

    typedef enum logic [2:0] {
        OP_NONE    = 3'b000,
        OP_BCD_DIV = 3'b001,
        OP_ADD     = 3'b010,
        OP_SUB     = 3'b011,
        OP_MUL     = 3'b100,
        OP_BIN_DIV = 3'b101
    } asu_op_t;

    typedef logic [STACK_DEPTH-1:0][WORD_W-1:0] asu_stack_t;

    typedef struct packed {
        logic [WORD_W-1:0] acc;
        asu_stack_t        stk;
        logic [FLAG_W-1:0] flags;
        logic              busy;
        logic              div_bcd;
        logic              ph_pend;
        logic              ph_write;
        logic [7:0]        ph_addr;
        logic              hready;
        logic              hresp;
        logic [WORD_W-1:0] hrdata;
    } asu_state_t;

    typedef struct packed {
        logic [WORD_W-1:0] quo;
        logic [HALF_W:0]   rem;
        logic [HALF_W-1:0] divisor;
        logic [5:0]        cnt;
        logic              run;
        logic              done;
    } asu_div_state_t;

endpackage

// >>> core/asu_top.sv
// Accumulator and eight-level accumulator stack with stack arithmetic.
// Assumes one AHB-Lite master that issues single word transfers only.
//
// Our own choices: the AHB-Lite register port and the register addresses.

// Behaviour
// - BCD divide: 8-digit accumulator by 4-digit level one; quotient, remainder.
// - BCD divide works on the full 32-bit accumulator.
// - Operand too large for the accumulator sets operand overflow flag.
// - Invalid BCD digit in a BCD operation sets non-BCD flag.
// - Binary add: accumulator plus level one into accumulator.
// - After binary add, level one is dropped and stack moves up.
// - Carry out of bit 15 sets carry16 flag.
// - Carry out of bit 31 sets carry32 flag.
// - Wrong sign after signed add or subtract sets sign error flag.
// - Zero flag follows whether the resulting accumulator is zero.
// - Negative flag follows whether the resulting accumulator is negative.
// - Binary subtract: accumulator minus level one into accumulator.
// - Subtract and multiply pop level one, stack moves up.
// - Separate borrow flags at 16-bit and 32-bit width.
// - Multiply 16-bit level one by 16-bit accumulator, 32-bit product.
// - Binary divide 32 by 16 bit; quotient to accumulator, remainder to level one.
// - A flag holds until a later operation touching it updates it.
// - Accumulator load pushes old accumulator into level one.
module asu_top (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);
    localparam int          NIB_W      = 4;
    localparam int          ADDR_W     = 8;
    localparam int          OP_W       = $bits(asu_pkg::asu_op_t);
    localparam int          STK_IDX_LO = 2;
    localparam int          STK_IDX_HI = 4;
    localparam int          REGION_LO  = 5;
    localparam int          REGION_HI  = 7;
    localparam logic [2:0]  HSIZE_WORD = 3'h2;

    // True when any of the low digits is not a decimal digit
    function automatic logic asu_non_bcd(
        input logic [asu_pkg::WORD_W-1:0] value,
        input int                         digits
    );
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < digits; i++) begin
            if (value[i*NIB_W +: NIB_W] > asu_pkg::BCD_MAX_DIGIT) begin
                bad = 1'b1;
            end
        end
        return bad;
    endfunction

    // Packed decimal to binary, most significant digit first
    function automatic logic [asu_pkg::WORD_W-1:0] asu_bcd_to_bin(
        input logic [asu_pkg::WORD_W-1:0] bcd,
        input int                         digits
    );
        logic [asu_pkg::WORD_W-1:0] bin;
        bin = '0;
        for (int i = digits - 1; i >= 0; i--) begin
            bin = bin * asu_pkg::TEN
                + {{(asu_pkg::WORD_W-NIB_W){1'b0}}, bcd[i*NIB_W +: NIB_W]};
        end
        return bin;
    endfunction

    // Shift-and-add-three; inputs stay within eight decimal digits here
    function automatic logic [asu_pkg::WORD_W-1:0] asu_bin_to_bcd(
        input logic [asu_pkg::WORD_W-1:0] bin
    );
        logic [asu_pkg::WORD_W-1:0] bcd;
        bcd = '0;
        for (int i = asu_pkg::WORD_W - 1; i >= 0; i--) begin
            for (int d = 0; d < asu_pkg::DIGITS_ACC; d++) begin
                if (bcd[d*NIB_W +: NIB_W] > asu_pkg::DABBLE_LIMIT) begin
                    bcd[d*NIB_W +: NIB_W] = bcd[d*NIB_W +: NIB_W] + asu_pkg::DABBLE_ADD;
                end
            end
            bcd = {bcd[asu_pkg::WORD_W-2:0], bin[i]};
        end
        return bcd;
    endfunction

    // Level one takes the value, the deepest level falls off
    function automatic asu_pkg::asu_stack_t asu_push(
        input asu_pkg::asu_stack_t        stk,
        input logic [asu_pkg::WORD_W-1:0] value
    );
        asu_pkg::asu_stack_t s;
        s = {stk[asu_pkg::STACK_DEPTH-2:0], value};
        return s;
    endfunction

    // Level one is dropped; zero refills the deepest level
    function automatic asu_pkg::asu_stack_t asu_pop(
        input asu_pkg::asu_stack_t stk
    );
        asu_pkg::asu_stack_t s;
        s = {{asu_pkg::WORD_W{1'b0}}, stk[asu_pkg::STACK_DEPTH-1:1]};
        return s;
    endfunction

    function automatic logic [asu_pkg::FLAG_W-1:0] asu_zero_neg(
        input logic [asu_pkg::FLAG_W-1:0] flags,
        input logic [asu_pkg::WORD_W-1:0] value
    );
        logic [asu_pkg::FLAG_W-1:0] f;
        f = flags;
        f[asu_pkg::FLG_ZERO] = (value == '0);
        f[asu_pkg::FLG_NEG]  = value[asu_pkg::WORD_W-1];
        return f;
    endfunction

    function automatic logic [asu_pkg::WORD_W-1:0] asu_read(
        input asu_pkg::asu_state_t s,
        input logic [ADDR_W-1:0]   addr
    );
        logic [asu_pkg::WORD_W-1:0] data;
        data = '0;
        if (addr == asu_pkg::ADDR_ACC) begin
            data = s.acc;
        end else if (addr == asu_pkg::ADDR_STATUS) begin
            data[asu_pkg::FLAG_W-1:0]  = s.flags;
            data[asu_pkg::STATUS_BUSY] = s.busy;
        end else if (addr[REGION_HI:REGION_LO] == asu_pkg::ADDR_STK_REGION) begin
            data = s.stk[addr[STK_IDX_HI:STK_IDX_LO]];
        end
        return data;
    endfunction

    asu_pkg::asu_state_t        st_r;
    asu_pkg::asu_state_t        st_nxt;
    asu_pkg::asu_op_t           cmd_op;
    logic                       addr_take;
    logic                       data_wr;
    logic                       wr_load;
    logic                       wr_cmd;
    logic                       add_go;
    logic                       sub_go;
    logic                       mul_go;
    logic                       bdiv_go;
    logic                       bcd_go;
    logic                       pop_go;
    logic                       res_upd;
    logic                       div_start;
    logic                       div_done;
    logic [31:0]                div_dividend;
    logic [15:0]                div_divisor;
    logic [31:0]                div_quo;
    logic [15:0]                div_rem;
    logic [31:0]                acc_q;
    logic [31:0]                lvl1_q;
    logic [31:0]                lvl2_q;
    logic [31:0]                deepest_q;
    logic [15:0]                acc_lo;
    logic [15:0]                lvl1_lo;
    logic [32:0]                sum_w;
    logic [16:0]                sum16_w;
    logic [31:0]                diff_w;
    logic [31:0]                prod_w;
    logic [31:0]                bcd_dvs_w;
    logic                       bcd_bad;
    logic                       dvs_big;
    logic                       dvs_zero;
    logic                       flag_ovf;
    logic                       flag_zero;
    logic                       flag_neg;
    logic                       flag_non_bcd;

    assign acc_q        = st_r.acc;
    assign lvl1_q       = st_r.stk[0];
    assign lvl2_q       = st_r.stk[1];
    assign deepest_q    = st_r.stk[asu_pkg::STACK_DEPTH-1];
    assign acc_lo       = acc_q[asu_pkg::HALF_W-1:0];
    assign lvl1_lo      = lvl1_q[asu_pkg::HALF_W-1:0];
    assign flag_ovf     = st_r.flags[asu_pkg::FLG_OVF];
    assign flag_zero    = st_r.flags[asu_pkg::FLG_ZERO];
    assign flag_neg     = st_r.flags[asu_pkg::FLG_NEG];
    assign flag_non_bcd = st_r.flags[asu_pkg::FLG_NON_BCD];

    // Only whole-word single transfers are taken
    assign addr_take = hsel && hready && (htrans == asu_pkg::HTRANS_NONSEQ)
                       && (hsize == HSIZE_WORD);
    assign data_wr   = st_r.ph_pend && st_r.ph_write;
    // Loads and commands are ignored while a divide runs
    assign wr_load   = data_wr && (st_r.ph_addr == asu_pkg::ADDR_ACC) && !st_r.busy;
    assign wr_cmd    = data_wr && (st_r.ph_addr == asu_pkg::ADDR_CMD) && !st_r.busy;
    assign cmd_op    = asu_pkg::asu_op_t'(hwdata[OP_W-1:0]);
    assign add_go    = wr_cmd && (cmd_op == asu_pkg::OP_ADD);
    assign sub_go    = wr_cmd && (cmd_op == asu_pkg::OP_SUB);
    assign mul_go    = wr_cmd && (cmd_op == asu_pkg::OP_MUL);
    assign bdiv_go   = wr_cmd && (cmd_op == asu_pkg::OP_BIN_DIV);
    assign bcd_go    = wr_cmd && (cmd_op == asu_pkg::OP_BCD_DIV);
    assign pop_go    = add_go || sub_go || mul_go;

    assign sum_w     = {1'b0, acc_q} + {1'b0, lvl1_q};
    assign sum16_w   = {1'b0, acc_lo} + {1'b0, lvl1_lo};
    assign diff_w    = acc_q - lvl1_q;
    assign prod_w    = {{asu_pkg::HALF_W{1'b0}}, acc_lo} * {{asu_pkg::HALF_W{1'b0}}, lvl1_lo};
    assign bcd_dvs_w = asu_bcd_to_bin(lvl1_q, asu_pkg::DIGITS_DIVSR);
    assign bcd_bad   = asu_non_bcd(acc_q, asu_pkg::DIGITS_ACC)
                       || asu_non_bcd(lvl1_q, asu_pkg::DIGITS_DIVSR);
    // A divisor wider than 16 bits (4 digits) cannot be handled
    assign dvs_big   = (lvl1_q[asu_pkg::WORD_W-1:asu_pkg::HALF_W] != '0);
    assign dvs_zero  = (lvl1_q == '0);

    always_comb begin
        st_nxt       = st_r;
        div_start    = 1'b0;
        div_dividend = '0;
        div_divisor  = '0;
        res_upd      = 1'b0;

        // Read data is fetched in the address phase so hrdata leaves a flop;
        // a read pipelined right behind a write sees the older value
        st_nxt.ph_pend = addr_take;
        st_nxt.hready  = 1'b1;
        st_nxt.hresp   = asu_pkg::HRESP_OKAY;
        if (addr_take) begin
            st_nxt.ph_write = hwrite;
            st_nxt.ph_addr  = haddr[ADDR_W-1:0];
            st_nxt.hrdata   = asu_read(st_r, haddr[ADDR_W-1:0]);
        end

        if (wr_load) begin
            st_nxt.stk = asu_push(st_r.stk, st_r.acc);
            st_nxt.acc = hwdata;
        end

        if (wr_cmd) begin
            unique case (cmd_op)
                asu_pkg::OP_ADD: begin
                    st_nxt.acc = sum_w[asu_pkg::WORD_W-1:0];
                    st_nxt.stk = asu_pop(st_r.stk);
                    st_nxt.flags[asu_pkg::FLG_CARRY16] = sum16_w[asu_pkg::HALF_W];
                    st_nxt.flags[asu_pkg::FLG_CARRY32] = sum_w[asu_pkg::WORD_W];
                    st_nxt.flags[asu_pkg::FLG_SIGN_ERR] =
                        (acc_q[asu_pkg::WORD_W-1] == lvl1_q[asu_pkg::WORD_W-1])
                        && (sum_w[asu_pkg::WORD_W-1] != acc_q[asu_pkg::WORD_W-1]);
                    res_upd = 1'b1;
                end
                asu_pkg::OP_SUB: begin
                    st_nxt.acc = diff_w;
                    st_nxt.stk = asu_pop(st_r.stk);
                    st_nxt.flags[asu_pkg::FLG_BORROW16] = (acc_lo < lvl1_lo);
                    st_nxt.flags[asu_pkg::FLG_BORROW32] = (acc_q < lvl1_q);
                    st_nxt.flags[asu_pkg::FLG_SIGN_ERR] =
                        (acc_q[asu_pkg::WORD_W-1] != lvl1_q[asu_pkg::WORD_W-1])
                        && (diff_w[asu_pkg::WORD_W-1] != acc_q[asu_pkg::WORD_W-1]);
                    res_upd = 1'b1;
                end
                asu_pkg::OP_MUL: begin
                    st_nxt.acc = prod_w;
                    st_nxt.stk = asu_pop(st_r.stk);
                    res_upd    = 1'b1;
                end
                asu_pkg::OP_BIN_DIV: begin
                    st_nxt.flags[asu_pkg::FLG_OVF] = dvs_big || dvs_zero;
                    if (dvs_big || dvs_zero) begin
                        res_upd = 1'b1;
                    end else begin
                        div_start      = 1'b1;
                        div_dividend   = acc_q;
                        div_divisor    = lvl1_lo;
                        st_nxt.busy    = 1'b1;
                        st_nxt.div_bcd = 1'b0;
                    end
                end
                asu_pkg::OP_BCD_DIV: begin
                    st_nxt.flags[asu_pkg::FLG_NON_BCD] = bcd_bad;
                    st_nxt.flags[asu_pkg::FLG_OVF]     = dvs_big || dvs_zero;
                    if (bcd_bad || dvs_big || dvs_zero) begin
                        res_upd = 1'b1;
                    end else begin
                        // Digits are turned to binary so one divider serves both
                        div_start      = 1'b1;
                        div_dividend   = asu_bcd_to_bin(acc_q, asu_pkg::DIGITS_ACC);
                        div_divisor    = bcd_dvs_w[asu_pkg::HALF_W-1:0];
                        st_nxt.busy    = 1'b1;
                        st_nxt.div_bcd = 1'b1;
                    end
                end
                asu_pkg::OP_NONE: begin
                end
                default: begin
                end
            endcase
        end

        if (div_done && st_r.busy) begin
            if (st_r.div_bcd) begin
                st_nxt.acc    = asu_bin_to_bcd(div_quo);
                st_nxt.stk[0] = asu_bin_to_bcd({{asu_pkg::HALF_W{1'b0}}, div_rem});
            end else begin
                st_nxt.acc    = div_quo;
                st_nxt.stk[0] = {{asu_pkg::HALF_W{1'b0}}, div_rem};
            end
            st_nxt.busy = 1'b0;
            res_upd     = 1'b1;
        end

        // Untouched flags keep their value until an operation using them
        if (res_upd) begin
            st_nxt.flags = asu_zero_neg(st_nxt.flags, st_nxt.acc);
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_r        <= '0;
            st_r.hready <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    asu_divider u_div (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .start     (div_start),
        .dividend  (div_dividend),
        .divisor   (div_divisor),
        .done      (div_done),
        .quotient  (div_quo),
        .remainder (div_rem)
    );

    assign hreadyout = st_r.hready;
    assign hresp     = st_r.hresp;
    assign hrdata    = st_r.hrdata;

    AST_ADD_SUM: assert property (@(posedge clk_sys) disable iff (!arst_n)
        add_go |=> acc_q == $past(acc_q) + $past(lvl1_q))
        else $error("add result wrong");

    AST_ADD_POP: assert property (@(posedge clk_sys) disable iff (!arst_n)
        add_go |=> lvl1_q == $past(lvl2_q))
        else $error("stack not moved up after add");

    AST_SUB_DIFF: assert property (@(posedge clk_sys) disable iff (!arst_n)
        sub_go |=> acc_q == $past(acc_q) - $past(lvl1_q))
        else $error("subtract result wrong");

    AST_MUL_PROD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        mul_go |=> acc_q == $past(acc_lo) * $past(lvl1_lo))
        else $error("multiply result wrong");

    AST_LOAD_PUSH: assert property (@(posedge clk_sys) disable iff (!arst_n)
        wr_load |=> lvl1_q == $past(acc_q))
        else $error("load did not push accumulator");

    AST_POP_CLEAR: assert property (@(posedge clk_sys) disable iff (!arst_n)
        pop_go |=> deepest_q == '0)
        else $error("deepest level not cleared");

    AST_ZERO_DIV_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (bdiv_go && dvs_zero) |=> flag_ovf && acc_q == $past(acc_q) && lvl1_q == $past(lvl1_q))
        else $error("zero divisor not refused");

    AST_NON_BCD_HOLD: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (bcd_go && bcd_bad) |=> flag_non_bcd && acc_q == $past(acc_q))
        else $error("non decimal digit not flagged");

    AST_ZERO_FLAG: assert property (@(posedge clk_sys) disable iff (!arst_n)
        res_upd |=> flag_zero == (acc_q == '0))
        else $error("zero flag wrong");

    AST_NEG_FLAG: assert property (@(posedge clk_sys) disable iff (!arst_n)
        res_upd |=> flag_neg == acc_q[asu_pkg::WORD_W-1])
        else $error("negative flag wrong");

    COV_ADD_POP: cover property (@(posedge clk_sys) disable iff (!arst_n) add_go);
    COV_SUB_POP: cover property (@(posedge clk_sys) disable iff (!arst_n) sub_go);
    COV_DIV_DONE: cover property (@(posedge clk_sys) disable iff (!arst_n)
        div_done && st_r.div_bcd);
    COV_NON_BCD: cover property (@(posedge clk_sys) disable iff (!arst_n) bcd_go && bcd_bad);
endmodule

// >>> verif/tb_top.sv
// Testbench: stack arithmetic driven over AHB-Lite, results read back.
// Assumes a command write of an asu_op_t code and busy at STATUS_BUSY.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 0;
    logic        arst_n  = 0;
    logic        hsel    = 0;
    logic        hwrite  = 0;
    logic        rdy;
    logic        hresp;
    logic [1:0]  htrans  = 0;
    logic [31:0] haddr   = 0;
    logic [31:0] hwdata  = 0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    int          miscompares = 0;
    int          samples_checked = 0;
    always #4 clk_sys = ~clk_sys;
    asu_top dut (.clk_sys(clk_sys), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy),
        .hreadyout(rdy), .hresp(hresp), .hrdata(hrdata));
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'h1; htrans <= asu_pkg::HTRANS_NONSEQ; hwrite <= w; haddr <= {24'h0, a};
        do @(posedge clk_sys); while (rdy !== 1'b1);
        hsel <= 1'h0; htrans <= 2'h0; hwdata <= d;
        do @(posedge clk_sys); while (rdy !== 1'b1);
        rd = hrdata;
        chk("hresp", {31'h0, asu_pkg::HRESP_OKAY}, {31'h0, hresp});
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // Fresh reset per case keeps the deeper stack levels at zero
    task automatic run(input logic [31:0] b, input logic [31:0] a, input asu_pkg::asu_op_t op,
                       input logic [31:0] ea, input logic [31:0] e1, input int f, input logic ef);
        arst_n <= 1'h0;
        repeat (10) @(posedge clk_sys);
        arst_n <= 1'h1;
        bus(1, asu_pkg::ADDR_ACC, b);
        bus(1, asu_pkg::ADDR_ACC, a);
        bus(0, 8'h20, 0);
        chk("level1 after load", b, rd);
        bus(1, asu_pkg::ADDR_CMD, {29'h0, op});
        do bus(0, asu_pkg::ADDR_STATUS, 0); while (rd[asu_pkg::STATUS_BUSY] !== 1'b0);
        chk("flag", {31'h0, ef}, {31'h0, rd[f]});
        bus(0, asu_pkg::ADDR_ACC, 0);
        chk("acc", ea, rd);
        bus(0, 8'h20, 0);
        chk("level1", e1, rd);
    endtask
    task automatic conclude();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
    initial begin
        run(32'h0000FFFF, 32'h1, asu_pkg::OP_ADD, 32'h10000, 0, asu_pkg::FLG_CARRY16, 1);
        run(32'hFFFFFFFF, 32'h1, asu_pkg::OP_ADD, 32'h0, 0, asu_pkg::FLG_CARRY32, 1);
        run(32'h7FFFFFFF, 32'h1, asu_pkg::OP_ADD, 32'h80000000, 0, asu_pkg::FLG_SIGN_ERR, 1);
        run(32'h1, 32'h0, asu_pkg::OP_SUB, 32'hFFFFFFFF, 0, asu_pkg::FLG_BORROW32, 1);
        run(32'h1, 32'h0, asu_pkg::OP_SUB, 32'hFFFFFFFF, 0, asu_pkg::FLG_NEG, 1);
        run(32'h5, 32'h5, asu_pkg::OP_SUB, 32'h0, 0, asu_pkg::FLG_ZERO, 1);
        run(32'h100, 32'h100, asu_pkg::OP_MUL, 32'h10000, 0, asu_pkg::FLG_ZERO, 0);
        run(32'h3, 32'h64, asu_pkg::OP_BIN_DIV, 32'h21, 32'h1, asu_pkg::FLG_OVF, 0);
        run(32'h0, 32'h5, asu_pkg::OP_BIN_DIV, 32'h5, 32'h0, asu_pkg::FLG_OVF, 1);
        run(32'h3, 32'h100, asu_pkg::OP_BCD_DIV, 32'h33, 32'h1, asu_pkg::FLG_NON_BCD, 0);
        run(32'h3, 32'h1A, asu_pkg::OP_BCD_DIV, 32'h1A, 32'h3, asu_pkg::FLG_NON_BCD, 1);
        conclude();
    end
endmodule
